// ==== core/eds_map.vh ====
// Purpose : constants for the evaporator defrost sequencer
// Assumes : included by core/eds_sequencer.v only
// Notes   : times in minutes, register offsets are word addresses
`ifndef EDS_MAP_VH
`define EDS_MAP_VH

// register offsets
`define EDS_REG_CTRL      4'h0
`define EDS_REG_PUMP_MIN  4'h1
`define EDS_REG_EQU_MIN   4'h2
`define EDS_REG_DRIP_MIN  4'h3
`define EDS_REG_MAN_MIN   4'h4
`define EDS_REG_FAN_CFG   4'h5
`define EDS_REG_FAN_SET   4'h6
`define EDS_REG_FAIL_MIN  4'h7
`define EDS_REG_STATUS    4'h8

// ctrl fields
`define EDS_CTRL_PUMP_EN  0
`define EDS_CTRL_EQU_EN   1
`define EDS_CTRL_FAN_CTL  2
`define EDS_CTRL_FAN_DLY  3
`define EDS_CTRL_FAN_TIME 4
`define EDS_CTRL_FAN_DEF  5

// fan sensor combination modes
`define EDS_FAN_ALL       2'h0
`define EDS_FAN_ANY       2'h1
`define EDS_FAN_AVG       2'h2
`define EDS_FAN_ONE       2'h3

// reset values
`define EDS_RST_CTRL      8'h0c
`define EDS_RST_PUMP_MIN  8'h0f
`define EDS_RST_EQU_MIN   8'h05
`define EDS_RST_DRIP_MIN  8'h02
`define EDS_RST_MAN_MIN   8'h2d
`define EDS_RST_FAN_CFG   8'h01
`define EDS_RST_FAN_SET   8'h00
`define EDS_RST_FAIL_MIN  8'h05

// limits
`define EDS_PUMP_MAX      8'h78
`define EDS_EQU_MAX       8'h3c

`endif

// ==== core/eds_sequencer.v ====
// Purpose : sequences one refrigeration circuit through defrost
// Assumes : tick_min_i is a one-cycle pulse once a minute, clk domain
// Notes   : sensors are signed 8-bit readings, same clock domain
//
// Overview of operation
// - manual request: pump-out if enabled, else manual
// - schedule: pump-out if enabled, else defrost
// - pump-out: suction open, other relays off
// - pump-out expiry with termination goes dripdown
// - pump-out expiry else defrost or manual
// - override in pump-out goes to dripdown
// - defrost states: only defrost relay on
// - defrost ends on term, schedule drop, override
// - manual ends on term, timer, override
// - after defrost equalize if enabled, else dripdown
// - equalize: equalize relay only, timer to dripdown
// - dripdown all off, expiry to cut-in/out
// - refrigeration: pump-out on, suction by temperature
// - shutdown all off, clears to cut-out
// - termination never shortens pump-out
// - equalize runs full length unless shutdown cuts it
// - manual defrost keeps enabled equalize
// - fan on in pump-out, configured after
// - fan sensors all/any/average/one, default any
// - selection applies only under fan conditions
// - fan restart uses defrost sensors only
// - failsafe timer restarts fan, default five
// - pump-out 0 to 120 minutes, default 15
// - equalize 0 to 60 minutes, default 5
// - timers obey shutdown and schedule inhibits
`timescale 1ns/1ps
`include "eds_map.vh"

module eds_sequencer #(
  parameter NSENS = 4                       // defrost sensor count
) (
  input  wire              clk_i,           // 250 mhz
  input  wire              rst_b_i,         // async, active low
  input  wire [3:0]        reg_addr_i,      // register word index
  input  wire [7:0]        reg_wdata_i,     // write data
  input  wire              reg_wr_i,        // write strobe
  input  wire              reg_rd_i,        // read strobe
  output reg  [7:0]        reg_rdata_o,     // read data, next cycle
  input  wire              tick_min_i,      // one-minute tick
  input  wire              sched_i,         // schedule active (pin)
  input  wire              man_req_i,       // manual defrost request
  input  wire              man_ovr_i,       // manual override / off
  input  wire              term_i,          // termination met (pin)
  input  wire              shutdown_i,      // shutdown input (pin)
  input  wire              inhibit_i,       // start blocked by program
  input  wire              cut_in_i,        // circuit temp calls cool
  input  wire              multi_case_i,    // more than one case sensor
  input  wire [8*NSENS-1:0] dfr_temp_i,     // defrost sensor readings
  output reg               suction_o,       // suction solenoid
  output reg  [7:0]        suction_pressure_regulator_valve_o, // 0..100
  output reg               pump_relay_o,    // pump-out relay
  output reg               defrost_relay_o, // defrost relay
  output reg               equ_relay_o,     // equalize relay
  output reg               fan_o            // evaporator fan
);

  // ************************************************************
  // states
  // ************************************************************
  localparam ST_CUTOUT = 8'h01;
  localparam ST_CUTIN  = 8'h02;
  localparam ST_PUMP   = 8'h04;
  localparam ST_DEF    = 8'h08;
  localparam ST_MAN    = 8'h10;
  localparam ST_EQU    = 8'h20;
  localparam ST_DRIP   = 8'h40;
  localparam ST_SHUT   = 8'h80;
  localparam [7:0] VALVE_OPEN = 8'h64;      // 100 percent

  // ************************************************************
  // input synchronisers (pins from outside)
  // ************************************************************
  reg  [5:0] sync_a;                        // first stage only
  reg  [5:0] sync_b;                        // usable stage
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {sched_i, man_req_i, man_ovr_i, term_i, shutdown_i,
                 inhibit_i};
      sync_b <= sync_a;
    end
  end
  wire s_sched = sync_b[5];
  wire s_man   = sync_b[4];
  wire s_ovr   = sync_b[3];
  wire s_term  = sync_b[2];
  wire s_shut  = sync_b[1];
  wire s_inh   = sync_b[0];

  // edge detect on requests, so one press starts one cycle
  reg  s_sched_d;                           // previous schedule
  reg  s_man_d;                             // previous manual req
  reg  s_ovr_d;                             // previous override
  wire sched_rise = s_sched & ~s_sched_d;
  wire man_rise   = s_man & ~s_man_d;
  wire ovr_rise   = s_ovr & ~s_ovr_d;

  // ************************************************************
  // registers
  // ************************************************************
  reg  [7:0] ctrl;                          // enables and fan setup
  reg  [7:0] pump_min;                      // pump-out minutes
  reg  [7:0] equ_min;                       // equalize minutes
  reg  [7:0] drip_min;                      // dripdown minutes
  reg  [7:0] man_min;                       // manual defrost minutes
  reg  [7:0] fan_cfg;                       // combo mode, sensor idx
  reg  [7:0] fan_set;                       // fan start setpoint
  reg  [7:0] fail_min;                      // fan failsafe minutes
  reg  [7:0] state;                         // one-hot state
  reg  [7:0] next_state;
  reg  [7:0] tmr;                           // phase minute counter
  reg        trig_man;                      // cycle started manually

  // clamp written pump-out and equalize durations to their documented ranges
  wire [7:0] pump_w = (reg_wdata_i > `EDS_PUMP_MAX) ?
                      `EDS_PUMP_MAX : reg_wdata_i;
  wire [7:0] equ_w  = (reg_wdata_i > `EDS_EQU_MAX) ?
                      `EDS_EQU_MAX : reg_wdata_i;

  // register writes
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl     <= `EDS_RST_CTRL;
      pump_min <= `EDS_RST_PUMP_MIN;
      equ_min  <= `EDS_RST_EQU_MIN;
      drip_min <= `EDS_RST_DRIP_MIN;
      man_min  <= `EDS_RST_MAN_MIN;
      fan_cfg  <= `EDS_RST_FAN_CFG;
      fan_set  <= `EDS_RST_FAN_SET;
      fail_min <= `EDS_RST_FAIL_MIN;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `EDS_REG_CTRL:     ctrl     <= reg_wdata_i;
        `EDS_REG_PUMP_MIN: pump_min <= pump_w;
        `EDS_REG_EQU_MIN:  equ_min  <= equ_w;
        `EDS_REG_DRIP_MIN: drip_min <= reg_wdata_i;
        `EDS_REG_MAN_MIN:  man_min  <= reg_wdata_i;
        `EDS_REG_FAN_CFG:  fan_cfg  <= reg_wdata_i;
        `EDS_REG_FAN_SET:  fan_set  <= reg_wdata_i;
        `EDS_REG_FAIL_MIN: fail_min <= reg_wdata_i;
        default: ;                          // unmapped: ignored
      endcase
    end
  end

  // register reads, data one cycle after strobe, zero otherwise
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `EDS_REG_CTRL:     reg_rdata_o <= ctrl;
        `EDS_REG_PUMP_MIN: reg_rdata_o <= pump_min;
        `EDS_REG_EQU_MIN:  reg_rdata_o <= equ_min;
        `EDS_REG_DRIP_MIN: reg_rdata_o <= drip_min;
        `EDS_REG_MAN_MIN:  reg_rdata_o <= man_min;
        `EDS_REG_FAN_CFG:  reg_rdata_o <= fan_cfg;
        `EDS_REG_FAN_SET:  reg_rdata_o <= fan_set;
        `EDS_REG_FAIL_MIN: reg_rdata_o <= fail_min;
        `EDS_REG_STATUS:   reg_rdata_o <= state;
        default:           reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ************************************************************
  // phase timer and next state
  // ************************************************************
  wire pump_en = ctrl[`EDS_CTRL_PUMP_EN];
  wire equ_en  = ctrl[`EDS_CTRL_EQU_EN];
  wire tmr_end = (tmr == 8'h00);            // phase time used up
  // a new cycle may not start under shutdown or a program inhibit
  wire start_ok = ~s_shut & ~s_inh;
  wire after_def = equ_en ? 1'b1 : 1'b0;    // equalize follows?

  always @* begin
    next_state = state;
    case (state)
      ST_CUTOUT, ST_CUTIN: begin
        if (man_rise && start_ok)
          next_state = pump_en ? ST_PUMP : ST_MAN;
        else if (sched_rise && start_ok)
          next_state = pump_en ? ST_PUMP : ST_DEF;
        else
          next_state = cut_in_i ? ST_CUTIN : ST_CUTOUT;
      end
      ST_PUMP: begin
        // termination is only looked at on expiry
        if (ovr_rise)
          next_state = ST_DRIP;
        else if (tmr_end && s_term)
          next_state = ST_DRIP;
        else if (tmr_end)
          next_state = trig_man ? ST_MAN : ST_DEF;
      end
      ST_DEF: begin
        if (s_term || !s_sched || ovr_rise)
          next_state = after_def ? ST_EQU : ST_DRIP;
      end
      ST_MAN: begin
        if (s_term || tmr_end || ovr_rise)
          next_state = after_def ? ST_EQU : ST_DRIP;
      end
      ST_EQU: begin
        if (tmr_end)
          next_state = ST_DRIP;
      end
      ST_DRIP: begin
        if (tmr_end)
          next_state = cut_in_i ? ST_CUTIN : ST_CUTOUT;
      end
      ST_SHUT: begin
        if (!s_shut)
          next_state = ST_CUTOUT;
      end
      default: next_state = ST_CUTOUT;
    endcase
    if (s_shut)
      next_state = ST_SHUT;
  end

  // state, trigger memory and timer reload on each entry
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state     <= ST_CUTOUT;
      tmr       <= 8'h00;
      trig_man  <= 1'b0;
      s_sched_d <= 1'b0;
      s_man_d   <= 1'b0;
      s_ovr_d   <= 1'b0;
    end else begin
      s_sched_d <= s_sched;
      s_man_d   <= s_man;
      s_ovr_d   <= s_ovr;
      state     <= next_state;
      if (next_state != state) begin
        // entry: load the new phase length, stopping the old timer
        case (next_state)
          ST_PUMP: tmr <= pump_min;
          ST_MAN:  tmr <= man_min;
          ST_EQU:  tmr <= equ_min;
          ST_DRIP: tmr <= drip_min;
          default: tmr <= 8'h00;
        endcase
        if ((state & (ST_CUTIN | ST_CUTOUT)) != 8'h00)
          trig_man <= man_rise;
      end else if (tick_min_i && !tmr_end) begin
        tmr <= tmr - 8'h01;
      end
    end
  end

  // ************************************************************
  // outputs per state
  // ************************************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      suction_o       <= 1'b0;
      suction_pressure_regulator_valve_o <= 8'h00;
      pump_relay_o    <= 1'b0;
      defrost_relay_o <= 1'b0;
      equ_relay_o     <= 1'b0;
    end else begin
      suction_o       <= 1'b0;
      suction_pressure_regulator_valve_o <= 8'h00;
      pump_relay_o    <= 1'b0;
      defrost_relay_o <= 1'b0;
      equ_relay_o     <= 1'b0;
      case (next_state)
        ST_PUMP: begin
          suction_o <= 1'b1;
          suction_pressure_regulator_valve_o <= VALVE_OPEN;
        end
        ST_DEF, ST_MAN: defrost_relay_o <= 1'b1;
        ST_EQU: equ_relay_o <= 1'b1;
        ST_CUTIN: begin
          pump_relay_o <= 1'b1;
          suction_o    <= 1'b1;
          suction_pressure_regulator_valve_o <= VALVE_OPEN;
        end
        ST_CUTOUT: pump_relay_o <= 1'b1;
        default: ;                          // drip, shut: all off
      endcase
    end
  end

  // ************************************************************
  // fan restart on defrost sensors
  // ************************************************************
  // only defrost sensors feed this, case sensors never do
  reg  signed [11:0] sum;
  reg                all_w;
  reg                any_w;
  reg  signed [7:0]  one_w;
  integer            k;
  always @* begin
    sum   = 12'sh000;
    all_w = 1'b1;
    any_w = 1'b0;
    one_w = 8'sh00;
    for (k = 0; k < NSENS; k = k + 1) begin
      sum = sum + {{4{dfr_temp_i[8*k+7]}}, dfr_temp_i[8*k +: 8]};
      if ($signed(dfr_temp_i[8*k +: 8]) < $signed(fan_set))
        any_w = 1'b1;
      else
        all_w = 1'b0;
      if (fan_cfg[7:2] == k[5:0])
        one_w = dfr_temp_i[8*k +: 8];
    end
  end
  wire signed [11:0] avg_x = sum / $signed(NSENS[11:0]);
  wire avg_w = avg_x < $signed({{4{fan_set[7]}}, fan_set});
  wire one_ok = one_w < $signed(fan_set);
  // mode applies only under the full fan delay setup
  wire sel_on = ctrl[`EDS_CTRL_FAN_CTL] & ctrl[`EDS_CTRL_FAN_DLY] &
                ~ctrl[`EDS_CTRL_FAN_TIME] & multi_case_i;
  reg  temp_ok;
  always @* begin
    if (!sel_on) begin
      temp_ok = any_w;
    end else begin
      case (fan_cfg[1:0])
        `EDS_FAN_ALL: temp_ok = all_w;
        `EDS_FAN_ANY: temp_ok = any_w;
        `EDS_FAN_AVG: temp_ok = avg_w;
        `EDS_FAN_ONE: temp_ok = one_ok;
        default:      temp_ok = any_w;
      endcase
    end
  end

  // fan held off after defrost until temperature or failsafe
  reg        fan_wait;                      // waiting to restart
  reg  [7:0] fail_tmr;                      // failsafe minutes left
  wire in_def = (next_state & (ST_DEF | ST_MAN | ST_EQU | ST_DRIP)) != 8'h00;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fan_wait <= 1'b0;
      fail_tmr <= 8'h00;
      fan_o    <= 1'b0;
    end else begin
      if (in_def) begin
        fan_wait <= ctrl[`EDS_CTRL_FAN_DLY];
        fail_tmr <= fail_min;
      end else if (fan_wait && (temp_ok || fail_tmr == 8'h00)) begin
        fan_wait <= 1'b0;
      end else if (fan_wait && tick_min_i) begin
        fail_tmr <= fail_tmr - 8'h01;
      end
      if (next_state == ST_PUMP)
        fan_o <= 1'b1;
      else if (in_def)
        fan_o <= ctrl[`EDS_CTRL_FAN_DEF];
      else if (next_state == ST_SHUT)
        fan_o <= 1'b0;
      else
        fan_o <= ~fan_wait | temp_ok;
    end
  end

endmodule

// ==== tb/eds_seq_props.sv ====
// Purpose : port-level properties of the defrost sequencer
// Assumes : one clock, async active-low reset
// Notes   : a zero equalize time is tracked from register writes
`timescale 1ns/1ps

module eds_seq_props (
  input wire       clk_i,
  input wire       rst_b_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       tick_min_i,
  input wire       shutdown_i,
  input wire       suction_o,
  input wire [7:0] suction_pressure_regulator_valve_o,
  input wire       pump_relay_o,
  input wire       defrost_relay_o,
  input wire       equ_relay_o,
  input wire       fan_o
);
  // ****************
  // helper logic
  // ****************
  reg [2:0] since_tick; // cycles since last tick, saturates
  reg       equ_zero;   // equalize programmed to zero minutes

  // zero equalize legally leaves at once, so remember it
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      since_tick <= 3'h7;
      equ_zero   <= 1'b0;
    end else begin
      if (tick_min_i)
        since_tick <= 3'h0;
      else if (since_tick != 3'h7)
        since_tick <= since_tick + 3'h1;
      if (reg_wr_i && reg_addr_i == 4'h2)
        equ_zero <= (reg_wdata_i == 8'h00);
    end
  end

  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence shut_held;
    shutdown_i [*6];
  endsequence
  sequence pump_phase;
    suction_o && !pump_relay_o;
  endsequence

  pump_outs_a : assert property (
    pump_phase |-> !defrost_relay_o && !equ_relay_o && fan_o)
    else $error("pump-out outputs wrong");
  valve_track_a : assert property (
    suction_pressure_regulator_valve_o == (suction_o ? 8'h64 : 8'h00))
    else $error("valve does not follow suction");
  defrost_outs_a : assert property (
    defrost_relay_o |-> !suction_o && !pump_relay_o && !equ_relay_o)
    else $error("defrost outputs wrong");
  equ_outs_a : assert property (
    equ_relay_o |-> !suction_o && !pump_relay_o && !defrost_relay_o)
    else $error("equalize outputs wrong");
  shut_off_a : assert property (
    shut_held |=> !suction_o && !pump_relay_o && !defrost_relay_o
      && !equ_relay_o)
    else $error("relays on during shutdown");
  defrost_start_a : assert property (
    $rose(defrost_relay_o) |-> $past(pump_relay_o || suction_o))
    else $error("defrost entered from wrong state");
  equ_entry_a : assert property (
    $rose(equ_relay_o) |-> $past(defrost_relay_o))
    else $error("equalize not entered from defrost");
  equ_full_a : assert property (
    $fell(equ_relay_o) |-> since_tick <= 3'h4 || equ_zero
      || $past(shutdown_i, 2) || $past(shutdown_i, 3))
    else $error("equalize cut short");
endmodule

bind eds_sequencer eds_seq_props u_props (
  .clk_i                              (clk_i),
  .rst_b_i                            (rst_b_i),
  .reg_addr_i                         (reg_addr_i),
  .reg_wdata_i                        (reg_wdata_i),
  .reg_wr_i                           (reg_wr_i),
  .tick_min_i                         (tick_min_i),
  .shutdown_i                         (shutdown_i),
  .suction_o                          (suction_o),
  .suction_pressure_regulator_valve_o (suction_pressure_regulator_valve_o),
  .pump_relay_o                       (pump_relay_o),
  .defrost_relay_o                    (defrost_relay_o),
  .equ_relay_o                        (equ_relay_o),
  .fan_o                              (fan_o)
);

// ==== tb/eds_plant.sv ====
// Purpose : far side: coil sensors, termination, cooling demand
// Assumes : bench commands termination and cooling demand
// Notes   : coil readings change every cycle, never stale
`timescale 1ns/1ps

module eds_plant #(
  parameter NSENS = 4                    // sensor count
) (
  input  wire               clk_i,       // bench clock
  input  wire               term_set_i,  // bench: termination met
  input  wire               cut_set_i,   // bench: cooling demand
  input  wire [NSENS-1:0]   cold_i,      // bench: sensor reads below zero
  output reg  [8*NSENS-1:0] dfr_temp_o,  // coil readings
  output reg                term_o,      // termination contact
  output reg                cut_in_o     // thermostat demand
);
  // fresh readings each cycle; only the sign is the bench's choice
  always @(posedge clk_i) begin
    for (int k = 0; k < NSENS; k++)
      dfr_temp_o[8*k +: 8] <= {cold_i[k], 7'($urandom)};
    term_o   <= term_set_i;
    cut_in_o <= cut_set_i;
  end
endmodule

// ==== tb/tb.sv ====
// Purpose : self-checking bench for the defrost sequencer
// Assumes : status register shows the state one-hot
// Notes   : pump-out, equalize and dripdown timers set to one minute to keep the run short
`timescale 1ns/1ps

module tb;
  logic        clk_i, rst_b_i, reg_wr_i, reg_rd_i, tick_min_i;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        sched_i, man_req_i, man_ovr_i, shutdown_i, inhibit_i;
  logic        multi_case_i, term_set, cut_set;
  logic [3:0]  cold;
  wire  [7:0]  reg_rdata_o, valve;
  wire  [31:0] dfr_temp_i;
  wire         term_i, cut_in_i, suction_o, pump_relay_o;
  wire         defrost_relay_o, equ_relay_o, fan_o;
  int          n_mismatch, tests_run;
  logic [7:0]  rst_tab [9] = '{8'h0c, 8'h0f, 8'h05, 8'h02, 8'h2d,
                               8'h01, 8'h00, 8'h05, 8'h01};
  logic [7:0]  r;

  eds_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tick_min_i(tick_min_i), .sched_i(sched_i), .man_req_i(man_req_i),
    .man_ovr_i(man_ovr_i), .term_i(term_i), .shutdown_i(shutdown_i),
    .inhibit_i(inhibit_i), .cut_in_i(cut_in_i),
    .multi_case_i(multi_case_i), .dfr_temp_i(dfr_temp_i),
    .suction_o(suction_o), .suction_pressure_regulator_valve_o(valve),
    .pump_relay_o(pump_relay_o), .defrost_relay_o(defrost_relay_o),
    .equ_relay_o(equ_relay_o), .fan_o(fan_o));
  eds_plant u_plant (.clk_i(clk_i), .term_set_i(term_set), .cold_i(cold),
    .cut_set_i(cut_set), .dfr_temp_o(dfr_temp_i), .term_o(term_i),
    .cut_in_o(cut_in_i));

  // ****************
  // clock, tasks
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // pins: sched, manual, override, termination, shutdown
  task automatic drive(input logic [4:0] v);
    @(posedge clk_i);
    {sched_i, man_req_i, man_ovr_i, term_set, shutdown_i} <= v;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic tick;
    @(posedge clk_i);
    tick_min_i <= 1'b1;
    @(posedge clk_i);
    tick_min_i <= 1'b0;
    repeat (4 + $urandom % 4) @(posedge clk_i);
  endtask

  // dripdown ends into refrigeration by random demand
  task automatic drip_out;
    @(posedge clk_i);
    cut_set <= 1'($urandom);
    tick;
    rd(4'h8, cut_set ? 8'h02 : 8'h01);
    chk({7'h0, pump_relay_o}, 8'h01);
  endtask

  // expected restart with set point 0: a cold sensor reads below it
  // average is only judged with all or no sensors cold
  function automatic logic fan_exp(input logic [7:0] cfg,
                                   input logic [3:0] c, input logic mc);
    if (!mc)
      return |c;
    case (cfg[1:0])
      2'h1:    return |c;
      2'h3:    return c[cfg[7:2]];
      default: return &c;
    endcase
  endfunction

  // one scheduled defrost, then the fan seen after dripdown
  task automatic fan_round(input logic [7:0] cfg, input logic [3:0] c,
                           input logic mc);
    wr(4'h5, cfg);
    cold         <= c;
    multi_case_i <= mc;
    drive(5'b10000);
    drive(5'b00000);
    drip_out;
    chk({7'h0, fan_o}, {7'h0, fan_exp(cfg, c, mc)});
  endtask

  task automatic close_out;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well above the fewer than a thousand cycles expected
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    close_out;
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, tick_min_i, reg_addr_i} = '0;
    {sched_i, man_req_i, man_ovr_i, shutdown_i, inhibit_i} = '0;
    {reg_wdata_i, term_set, cut_set, multi_case_i, cold} = '0;
    void'($urandom(32'h18e1));
    repeat (20) @(posedge clk_i);
    rst_b_i      <= 1'b1;
    multi_case_i <= 1'b1;
    foreach (rst_tab[i]) rd(4'(i), rst_tab[i]);
    rd(4'h9, 8'h00);
    wr(4'h1, 8'hc8);
    rd(4'h1, 8'h78);
    wr(4'h2, 8'h64);
    rd(4'h2, 8'h3c);
    r = 8'($urandom % 121);
    wr(4'h1, r);
    rd(4'h1, r);
    for (int m = 0; m < 4; m++) begin
      wr(4'h5, 8'(m));
      rd(4'h5, 8'(m));
    end
    for (int a = 1; a < 4; a++) wr(4'(a), 8'h01);
    wr(4'h0, 8'h0f);
    drive(5'b10000);
    rd(4'h8, 8'h04);
    chk({suction_o, pump_relay_o, defrost_relay_o, equ_relay_o, fan_o},
        8'h11);
    drive(5'b10010);
    rd(4'h8, 8'h04);
    tick;
    rd(4'h8, 8'h40);
    drive(5'b00000);
    drip_out;
    drive(5'b01000);
    rd(4'h8, 8'h04);
    tick;
    rd(4'h8, 8'h10);
    drive(5'b01100);
    rd(4'h8, 8'h20);
    drive(5'b00010);
    rd(4'h8, 8'h20);
    tick;
    rd(4'h8, 8'h40);
    drive(5'b00000);
    drip_out;
    drive(5'b01000);
    drive(5'b01100);
    rd(4'h8, 8'h40);
    drive(5'b00000);
    drip_out;
    wr(4'h0, 8'h0e);
    drive(5'b10000);
    rd(4'h8, 8'h08);
    chk({4'h0, suction_o, pump_relay_o, defrost_relay_o, equ_relay_o},
        8'h02);
    drive(5'b00000);
    rd(4'h8, 8'h20);
    tick;
    drip_out;
    wr(4'h0, 8'h0c);
    wr(4'h4, 8'h02);
    drive(5'b01000);
    rd(4'h8, 8'h10);
    tick;
    rd(4'h8, 8'h10);
    tick;
    rd(4'h8, 8'h40);
    drive(5'b00000);
    drip_out;
    drive(5'b10000);
    drive(5'b10010);
    rd(4'h8, 8'h40);
    drive(5'b00000);
    drip_out;
    cut_set <= 1'b0;
    drive(5'b10000);
    drive(5'b10001);
    rd(4'h8, 8'h80);
    chk({4'h0, suction_o, pump_relay_o, defrost_relay_o, equ_relay_o},
        8'h00);
    drive(5'b00000);
    rd(4'h8, 8'h01);
    inhibit_i <= 1'b1;
    drive(5'b00000);
    drive(5'b10000);
    rd(4'h8, 8'h01);
    inhibit_i <= 1'b0;
    drive(5'b00000);
    wr(4'h7, 8'h01);
    wr(4'h0, 8'h2c);
    drive(5'b10000);
    chk({7'h0, fan_o}, 8'h01);
    wr(4'h0, 8'h0c);
    drive(5'b00000);
    chk({7'h0, fan_o}, 8'h00);
    drip_out;
    chk({7'h0, fan_o}, 8'h00);
    tick;
    chk({7'h0, fan_o}, 8'h01);
    fan_round(8'h00, 4'hf, 1'b1);
    fan_round(8'h00, 4'h7, 1'b1);
    fan_round(8'h00, 4'h1, 1'b0);
    fan_round(8'h02, 4'hf, 1'b1);
    fan_round(8'h02, 4'h0, 1'b1);
    fan_round(8'h07, 4'h2, 1'b1);
    fan_round(8'h07, 4'hd, 1'b1);
    repeat (4) fan_round(8'($urandom % 2), 4'($urandom), 1'b1);
    close_out;
  end
endmodule
